/* core/flash_nv_pkg.sv */
/*
 * Shared constants and carrier types for the flash and OTP read front end:
 * register offsets, field layouts, reset values, power codes and access
 * timing figures.
 * Assumes a 32-bit APB register port and a 16-bit word addressed core bus.
 */
package flash_nv_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int APB_AW  = 8;
    localparam int DATA_W  = 32;
    localparam int ADDR_W  = 22;
    localparam int WAKE_W  = 16;
    localparam int RAND_W  = 4;
    localparam int PAGE_W  = 4;
    localparam int ACC_W   = 5;
    localparam int MODE_W  = 2;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [APB_AW-1:0] OFS_POWER  = 8'h00;
    localparam logic [APB_AW-1:0] OFS_STATUS = 8'h04;
    localparam logic [APB_AW-1:0] OFS_STBY   = 8'h08;
    localparam logic [APB_AW-1:0] OFS_ACT    = 8'h0C;
    localparam logic [APB_AW-1:0] OFS_BANK   = 8'h10;
    localparam logic [APB_AW-1:0] OFS_OTP    = 8'h14;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int RAND_LSB      = 0;
    localparam int PAGE_LSB      = 8;
    localparam int ST_WAKE_BIT   = 2;
    localparam int ST_ACCESS_BIT = 3;

    // ------------------------------------------------------------------
    // Power codes, ordered so that a larger code is a higher power state
    // ------------------------------------------------------------------
    localparam logic [MODE_W-1:0] PWR_SLEEP   = 2'h0;
    localparam logic [MODE_W-1:0] PWR_STANDBY = 2'h1;
    localparam logic [MODE_W-1:0] PWR_ODD     = 2'h2;
    localparam logic [MODE_W-1:0] PWR_ACTIVE  = 2'h3;

    // ------------------------------------------------------------------
    // Reset values and fixed timing
    // ------------------------------------------------------------------
    localparam logic [WAKE_W-1:0] STBY_WAKE_RST   = 16'h01FF;
    localparam logic [WAKE_W-1:0] ACT_WAKE_RST    = 16'h01FF;
    localparam logic [RAND_W-1:0] RAND_WAIT_RST   = 4'hF;
    localparam logic [PAGE_W-1:0] PAGE_WAIT_RST   = 4'hF;
    localparam logic [ACC_W-1:0]  OTP_WAIT_RST    = 5'h1F;
    localparam logic [ACC_W-1:0]  PASSWORD_WAIT   = 5'h10;
    localparam int                ROW_BITS        = 2048;
    localparam int                WORD_BITS       = 16;
    localparam int                ROW_SHIFT       = $clog2(ROW_BITS / WORD_BITS);
    localparam int                OTP_WORDS       = 1024;

    // ------------------------------------------------------------------
    // Core bus carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic              valid;
        logic              write;
        logic              fetch;
        logic              prog_space;
        logic              wide;
        logic [ADDR_W-1:0] addr;
    } cpu_req_t;

    typedef struct packed {
        logic              ready;
        logic [DATA_W-1:0] data;
    } cpu_rsp_t;

endpackage

/* core/wait_counter.sv */
/*
 * Loadable down counter used for wake-up delays and access wait states.
 * Assumes load is a one-cycle strobe from the owning state machine.
 */
`timescale 1ns/1ps

module wait_counter #(
    parameter int W = 16
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         load,
    input  wire logic [W-1:0] value,
    output logic              zero
);

    if (W < 1) begin : g_bad_width
        $error("wait_counter width must be at least one");
    end

    logic [W-1:0] cnt_q;

    // A fresh load wins over counting so the newest figure is always used.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= '0;
        end else if (load) begin
            cnt_q <= value;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - W'(1);
        end
    end

    assign zero = (cnt_q == '0);

endmodule // wait_counter

/* core/flash_otp_power_wait_control.sv */
/*
 * Read front end for the flash bank and OTP block: shared power state with
 * timed wake-up, wait-state insertion, ignored writes and secured reads.
 * Assumes the core holds a request until it sees ready, the array returns
 * data asynchronously from mem_addr, and APB runs on the same clock.
 */
`timescale 1ns/1ps

module flash_otp_power_wait_control
    import flash_nv_pkg::*;
#(
    parameter logic [ADDR_W-1:0] FLASH_BASE = 22'h30_0000,
    parameter logic [ADDR_W-1:0] FLASH_LAST = 22'h33_FFFF,
    parameter logic [ADDR_W-1:0] OTP_BASE   = 22'h38_0000,
    parameter logic [ADDR_W-1:0] PASS_BASE  = 22'h33_FFF8,
    parameter logic [ADDR_W-1:0] PASS_LAST  = 22'h33_FFFF
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic [APB_AW-1:0] paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [DATA_W-1:0] pwdata,
    output logic      [DATA_W-1:0] prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire cpu_req_t          cpu_req,
    output cpu_rsp_t               cpu_rsp,
    input  wire logic              csm_locked,
    input  wire logic              secure_zone,
    output logic                   mem_en,
    output logic                   mem_otp,
    output logic      [ADDR_W-1:0] mem_addr,
    input  wire logic [DATA_W-1:0] mem_rdata,
    output logic      [MODE_W-1:0] power_state
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OTP_LAST = OTP_BASE + ADDR_W'(OTP_WORDS - 1);
    if (FLASH_LAST < FLASH_BASE || PASS_LAST < PASS_BASE || ADDR_W <= ROW_SHIFT) begin : g_bad_cfg
        $error("address map empty or too narrow for a flash row");
    end

    // ------------------------------------------------------------------
    // State declarations
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {wk_idle, wk_stby, wk_act} wake_t;
    typedef enum logic [1:0] {acc_idle, acc_wake, acc_wait, acc_done} acc_t;

    wake_t                     wake_q;
    acc_t                      acc_q;
    logic [MODE_W-1:0]         power_q;
    logic [MODE_W-1:0]         target_q;
    logic [WAKE_W-1:0]         stby_cnt_q;
    logic [WAKE_W-1:0]         act_cnt_q;
    logic [RAND_W-1:0]         rand_wait_q;
    logic [PAGE_W-1:0]         page_wait_q;
    logic [ACC_W-1:0]          otp_wait_q;
    logic [ADDR_W-ROW_SHIFT-1:0] row_q;
    logic                      row_valid_q;
    cpu_rsp_t                  rsp_q;
    logic                      mem_en_q;
    logic                      mem_otp_q;
    logic [ADDR_W-1:0]         mem_addr_q;
    logic [DATA_W-1:0]         prdata_q;
    logic                      pready_q;
    logic                      pslverr_q;

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    logic                      apb_setup;
    logic                      apb_wr;
    logic                      wr_power;
    logic [MODE_W-1:0]         wr_mode;
    logic                      sw_down;
    logic [DATA_W-1:0]         prdata_d;
    logic                      unmapped;
    assign apb_setup = psel && !penable;
    assign apb_wr    = psel && penable && pwrite && pready_q;
    assign wr_power  = apb_wr && (paddr == OFS_POWER);
    // The unused code 2 is folded onto standby so the ordering stays total.
    assign wr_mode   = (pwdata[MODE_W-1:0] == PWR_ODD) ? PWR_STANDBY : pwdata[MODE_W-1:0];
    assign sw_down   = wr_power && (wr_mode < power_q);

    always_comb begin
        prdata_d = '0;
        unmapped = 1'b0;
        unique case (paddr)
            OFS_POWER:  prdata_d[MODE_W-1:0] = power_q;
            OFS_STATUS: begin
                prdata_d[MODE_W-1:0]    = power_q;
                prdata_d[ST_WAKE_BIT]   = (wake_q != wk_idle);
                prdata_d[ST_ACCESS_BIT] = (acc_q != acc_idle);
            end
            OFS_STBY:   prdata_d[WAKE_W-1:0] = stby_cnt_q;
            OFS_ACT:    prdata_d[WAKE_W-1:0] = act_cnt_q;
            OFS_BANK: begin
                prdata_d[RAND_LSB +: RAND_W] = rand_wait_q;
                prdata_d[PAGE_LSB +: PAGE_W] = page_wait_q;
            end
            OFS_OTP:    prdata_d[ACC_W-1:0] = otp_wait_q;
            default:    unmapped = 1'b1;
        endcase
    end

    // Every transfer is answered in its first access cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= '0;
        end else begin
            pready_q  <= apb_setup;
            pslverr_q <= apb_setup && unmapped;
            prdata_q  <= apb_setup && !pwrite ? prdata_d : '0;
        end
    end

    // ------------------------------------------------------------------
    // Timing registers
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stby_cnt_q  <= STBY_WAKE_RST;
            act_cnt_q   <= ACT_WAKE_RST;
            rand_wait_q <= RAND_WAIT_RST;
            page_wait_q <= PAGE_WAIT_RST;
            otp_wait_q  <= OTP_WAIT_RST;
        end else if (apb_wr) begin
            if (paddr == OFS_STBY) begin
                stby_cnt_q <= pwdata[WAKE_W-1:0];
            end
            if (paddr == OFS_ACT) begin
                act_cnt_q <= pwdata[WAKE_W-1:0];
            end
            if (paddr == OFS_BANK) begin
                rand_wait_q <= pwdata[RAND_LSB +: RAND_W];
                page_wait_q <= pwdata[PAGE_LSB +: PAGE_W];
            end
            if (paddr == OFS_OTP) begin
                otp_wait_q <= pwdata[ACC_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Power state and wake-up sequencing
    // ------------------------------------------------------------------
    logic                      wake_zero;
    logic                      go_stby;
    logic                      go_act;
    logic [WAKE_W-1:0]         wake_val;
    assign go_stby = !sw_down && (wake_q == wk_idle) && (target_q > power_q)
                     && (power_q == PWR_SLEEP);
    assign go_act  = !sw_down && (((wake_q == wk_idle) && (target_q > power_q)
                     && (power_q == PWR_STANDBY))
                     || ((wake_q == wk_stby) && wake_zero && (target_q == PWR_ACTIVE)));
    assign wake_val = go_stby ? stby_cnt_q : act_cnt_q;

    wait_counter #(.W(WAKE_W)) u_wake_cnt (
        .pclk    (pclk),
        .presetn (presetn),
        .load    (go_stby || go_act),
        .value   (wake_val),
        .zero    (wake_zero)
    );

    // The target is where waking heads; a waiting access forces it to active.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            target_q <= PWR_SLEEP;
        end else if (acc_q == acc_wake) begin
            target_q <= PWR_ACTIVE;
        end else if (wr_power) begin
            target_q <= wr_mode;
        end
    end

    // A single state serves bank, pump, flash array and OTP alike.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_q <= PWR_SLEEP;
            wake_q  <= wk_idle;
        end else if (sw_down) begin
            power_q <= wr_mode;
            wake_q  <= wk_idle;
        end else begin
            unique case (wake_q)
                wk_idle: begin
                    if (go_stby) begin
                        wake_q <= wk_stby;
                    end else if (go_act) begin
                        wake_q <= wk_act;
                    end
                end
                wk_stby: begin
                    if (wake_zero) begin
                        power_q <= PWR_STANDBY;
                        wake_q  <= go_act ? wk_act : wk_idle;
                    end
                end
                wk_act: begin
                    if (wake_zero) begin
                        power_q <= PWR_ACTIVE;
                        wake_q  <= wk_idle;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Core access decode and wait selection
    // ------------------------------------------------------------------
    logic                      in_flash;
    logic                      in_otp;
    logic                      in_pass;
    logic                      in_range;
    logic                      is_read;
    logic                      acc_load;
    logic                      acc_zero;
    logic                      same_row;
    logic                      wide_ok;
    logic [ACC_W-1:0]          acc_val;
    logic [DATA_W-1:0]         read_word;
    // Address space is not looked at in decode: OTP is selected and timed alike in both spaces.
    assign in_flash = (cpu_req.addr >= FLASH_BASE) && (cpu_req.addr <= FLASH_LAST);
    assign in_otp   = (cpu_req.addr >= OTP_BASE) && (cpu_req.addr <= OTP_LAST);
    assign in_pass  = (cpu_req.addr >= PASS_BASE) && (cpu_req.addr <= PASS_LAST);
    assign in_range = in_flash || in_otp;
    assign is_read  = cpu_req.valid && !cpu_req.write && in_range;
    assign same_row = row_valid_q && (row_q == cpu_req.addr[ADDR_W-1:ROW_SHIFT]);
    assign acc_load = is_read && (power_q == PWR_ACTIVE)
                      && ((acc_q == acc_idle) || (acc_q == acc_wake));

    always_comb begin
        acc_val = {1'b0, rand_wait_q};
        if (in_pass) begin
            acc_val = PASSWORD_WAIT;
        end else if (in_otp) begin
            acc_val = otp_wait_q;
        end else if (same_row) begin
            acc_val = {1'b0, page_wait_q};
        end
    end

    wait_counter #(.W(ACC_W)) u_acc_cnt (
        .pclk    (pclk),
        .presetn (presetn),
        .load    (acc_load),
        .value   (acc_val),
        .zero    (acc_zero)
    );

    // Fetches are always 32 bits; program space data reads are cut to 16.
    assign wide_ok   = cpu_req.fetch || (cpu_req.wide && !cpu_req.prog_space);
    assign read_word = wide_ok ? mem_rdata : {16'h0000, mem_rdata[WORD_BITS-1:0]};

    // Row history is forgotten whenever the bank leaves active.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            row_q       <= '0;
            row_valid_q <= 1'b0;
        end else if (power_q != PWR_ACTIVE) begin
            row_valid_q <= 1'b0;
        end else if (acc_load && in_flash) begin
            row_q       <= cpu_req.addr[ADDR_W-1:ROW_SHIFT];
            row_valid_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Core access sequencing
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_q <= acc_idle;
            rsp_q <= '0;
        end else begin
            unique case (acc_q)
                acc_idle: begin
                    if (cpu_req.valid && (cpu_req.write || !in_range)) begin
                        acc_q       <= acc_done;
                        rsp_q.ready <= 1'b1;
                        rsp_q.data  <= '0;
                    end else if (acc_load) begin
                        acc_q <= acc_wait;
                    end else if (is_read) begin
                        acc_q <= acc_wake;
                    end
                end
                acc_wake: begin
                    if (acc_load) begin
                        acc_q <= acc_wait;
                    end
                end
                acc_wait: begin
                    if (acc_zero) begin
                        acc_q       <= acc_done;
                        rsp_q.ready <= 1'b1;
                        // Locked data is suppressed only after the full wait.
                        rsp_q.data  <= (csm_locked && !secure_zone) ? '0 : read_word;
                    end
                end
                acc_done: begin
                    acc_q       <= acc_idle;
                    rsp_q.ready <= 1'b0;
                end
            endcase
        end
    end

    // The array sees a stable address for the whole wait.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_en_q   <= 1'b0;
            mem_otp_q  <= 1'b0;
            mem_addr_q <= '0;
        end else if (acc_load) begin
            mem_en_q   <= 1'b1;
            mem_otp_q  <= in_otp;
            mem_addr_q <= cpu_req.addr;
        end else if (acc_q == acc_wait && acc_zero) begin
            mem_en_q   <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign prdata      = prdata_q;
    assign pready      = pready_q;
    assign pslverr     = pslverr_q;
    assign cpu_rsp     = rsp_q;
    assign mem_en      = mem_en_q;
    assign mem_otp     = mem_otp_q;
    assign mem_addr    = mem_addr_q;
    assign power_state = power_q;

endmodule // flash_otp_power_wait_control

/* verif/flash_nv_props_properties.sv */
/* Concurrent checks on the flash front end ports, bound into its top.
   Assumes one core request at a time and APB on the same clock. */
`timescale 1ns/1ps
module flash_nv_props
    import flash_nv_pkg::*;
#(
    parameter logic [ADDR_W-1:0] PASS_BASE = 22'h33_FFF8,
    parameter logic [ADDR_W-1:0] PASS_LAST = 22'h33_FFFF
) (
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [DATA_W-1:0] pwdata,
    input wire logic              pready,
    input wire cpu_req_t          cpu_req,
    input wire cpu_rsp_t          cpu_rsp,
    input wire logic              csm_locked,
    input wire logic              secure_zone,
    input wire logic              mem_en,
    input wire logic              mem_otp,
    input wire logic [ADDR_W-1:0] mem_addr,
    input wire logic [MODE_W-1:0] power_state
);
    // Wait-phase length is counted here because it can exceed a legal repetition.
    logic [5:0]       en_cnt_q;
    logic [ACC_W-1:0] otp_q;
    logic             wr;
    assign wr = psel && penable && pready && pwrite;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_cnt_q <= 6'h00;
            otp_q    <= OTP_WAIT_RST;
        end else begin
            en_cnt_q <= mem_en ? en_cnt_q + 6'h01 : 6'h00;
            if (wr && paddr == OFS_OTP) otp_q <= pwdata[ACC_W-1:0];
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    reset_sleep_a: assert property ($rose(presetn) |-> power_state == PWR_SLEEP)
        else $error("not asleep after reset");
    one_state_a: assert property (power_state != PWR_ODD)
        else $error("power state code unused");
    awake_read_a: assert property (mem_en |-> power_state == PWR_ACTIVE)
        else $error("array read before active");
    write_fast_a: assert property ($rose(cpu_req.valid) && cpu_req.write
        |=> cpu_rsp.ready && cpu_rsp.data == '0) else $error("write not one cycle");
    lower_now_a: assert property (wr && paddr == OFS_POWER && pwdata[1:0] != PWR_ODD
        && pwdata[1:0] < power_state |=> power_state == $past(pwdata[1:0]))
        else $error("lowering delayed");
    pass_wait_a: assert property ($fell(mem_en) && $past(mem_addr) >= PASS_BASE
        && $past(mem_addr) <= PASS_LAST |-> en_cnt_q == 6'h11) else $error("password wait");
    otp_wait_a: assert property ($fell(mem_en) && $past(mem_otp)
        |-> en_cnt_q == {1'b0, otp_q} + 6'h01) else $error("otp wait");
    done_ready_a: assert property ($fell(mem_en) |-> cpu_rsp.ready)
        else $error("no ready after wait");
    locked_zero_a: assert property (cpu_rsp.ready && csm_locked && !secure_zone
        |-> cpu_rsp.data == '0) else $error("locked read leaked");
endmodule // flash_nv_props

bind flash_otp_power_wait_control flash_nv_props #(
    .PASS_BASE(PASS_BASE),
    .PASS_LAST(PASS_LAST)
) u_props (.*);

/* verif/nv_array_model.sv */
/* Behavioural flash and OTP array behind the front end.
   Assumes data is read combinationally from the word address. */
`timescale 1ns/1ps
module nv_array_model
    import flash_nv_pkg::*;
(
    input  wire logic              pclk,
    input  wire logic              mem_en,
    input  wire logic [ADDR_W-1:0] mem_addr,
    output logic      [DATA_W-1:0] mem_rdata
);
    logic [DATA_W-1:0] junk_q = 32'h0000_0000;
    // Outside a read the data stays zero: junk_q starts at zero and its negation is still zero.
    always_ff @(posedge pclk) junk_q <= ~junk_q + 32'h0000_0001;
    assign mem_rdata = mem_en ? {~mem_addr[15:0], mem_addr[15:0]} : junk_q;
endmodule // nv_array_model

/* verif/flash_otp_power_wait_control_tb.sv */
/* Self-checking bench for the flash front end.
   Assumes the array model data pattern and the default address map. */
`timescale 1ns/1ps
`define CHK(g, w) begin num_checks++; if ((g) !== (w)) begin fails++; \
    $display("mismatch t=%0t got=%h want=%h", $time, g, w); end end
module flash_otp_power_wait_control_tb
    import flash_nv_pkg::*;
;
    logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic              csm_locked, secure_zone, mem_en, mem_otp;
    logic [APB_AW-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata, mem_rdata;
    logic [ADDR_W-1:0] mem_addr;
    logic [MODE_W-1:0] power_state;
    cpu_req_t          cpu_req;
    cpu_rsp_t          cpu_rsp;
    logic [15:0]       r;
    logic [14:0]       prev;
    logic [3:0]        rw;
    logic [4:0]        ow;
    logic [32:0]       ea, apb_q[$];
    logic [95:0]       e, cpu_q[$];
    int                fails, num_checks, cyc, t0, lat;
    flash_otp_power_wait_control dut (.*);
    nv_array_model model (.*);
    initial forever #25 pclk = ~pclk;
    always @(negedge pclk) cyc++;
    function automatic logic [15:0] nxt(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [32:0] x);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        if (!w) apb_q.push_back(x);
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Kind k is {write, fetch, program space, wide}; lo and hi bound the latency.
    task automatic cpu(input logic [3:0] k, input logic [21:0] a, input int lo, input int hi);
        logic [31:0] p;
        @(posedge pclk);
        p = {~a[15:0], a[15:0]};
        if (!k[2] && (k[1] || !k[0])) p[31:16] = 16'h0000;
        if (k[3] || (csm_locked && !secure_zone)) p = '0;
        cpu_req <= {1'b1, k, a};
        t0 = cyc + 1;
        cpu_q.push_back({lo, hi, p});
        do @(posedge pclk); while (cpu_rsp.ready !== 1'b1);
        cpu_req.valid <= 1'b0;
    endtask
    task automatic rows(input logic [3:0] pg);
        logic [21:0] a;
        int          n;
        apb(1'b1, OFS_BANK, {20'h0, pg, 4'h0, rw}, '0);
        for (int i = 0; i < 8; i++) begin
            r = nxt(r);
            a = 22'h30_0000 + r[8:0];
            n = 2 + ((a[21:7] == prev) ? pg : rw);
            cpu({1'b0, r[11:9]}, a, n, n);
            prev = a[21:7];
        end
    endtask
    always @(posedge pclk) begin
        if (pready === 1'b1 && pwrite === 1'b0) begin
            ea = apb_q.pop_front();
            `CHK({pslverr, prdata}, ea)
        end
        if (cpu_rsp.ready === 1'b1) begin
            e = cpu_q.pop_front();
            lat = cyc - t0;
            `CHK(cpu_rsp.data, e[31:0])
            `CHK(lat >= e[95:64] && lat <= e[63:32], 1'b1)
        end
    end
    task automatic print_verdict;
        if (fails == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge pclk);
        fails++;
        print_verdict();
    end
    initial begin
        {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {cpu_req, csm_locked, secure_zone, fails, num_checks, cyc} = '0;
        r = 16'h0055;
        prev = '1;
        rw = RAND_WAIT_RST;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, OFS_POWER, '0, 33'h0);
        apb(1'b0, OFS_STATUS, '0, 33'h0);
        apb(1'b0, OFS_STBY, '0, {17'h0, STBY_WAKE_RST});
        apb(1'b0, OFS_ACT, '0, {17'h0, ACT_WAKE_RST});
        apb(1'b0, OFS_BANK, '0, {21'h0, PAGE_WAIT_RST, 4'h0, RAND_WAIT_RST});
        apb(1'b0, OFS_OTP, '0, {28'h0, OTP_WAIT_RST});
        apb(1'b0, 8'h18, '0, {1'b1, 32'h0});
        cpu(4'h8, 22'h30_0040, 1, 1);
        apb(1'b0, OFS_POWER, '0, 33'h0);
        cpu(4'h6, 22'h30_0000, 1030, 1050);
        prev = 15'h6000;
        apb(1'b0, OFS_POWER, '0, 33'h3);
        rows(4'h0);
        rw = r[7:4];
        rows(r[3:0]);
        r = nxt(r);
        ow = r[4:0];
        apb(1'b1, OFS_OTP, {27'h0, ow}, '0);
        cpu(4'h2, 22'h38_0000 + r[9:0], 2 + ow, 2 + ow);
        cpu(4'h1, 22'h38_0000 + r[9:0], 2 + ow, 2 + ow);
        cpu(4'h0, 22'h33_FFF9, 18, 18);
        csm_locked <= 1'b1;
        cpu(4'h1, 22'h38_0001, 2 + ow, 2 + ow);
        secure_zone <= 1'b1;
        cpu(4'h1, 22'h38_0002, 2 + ow, 2 + ow);
        csm_locked <= 1'b0;
        apb(1'b1, OFS_POWER, 32'h1, '0);
        apb(1'b0, OFS_POWER, '0, 33'h1);
        cpu(4'h0, 22'h30_0100, 511 + rw, 522 + rw);
        apb(1'b1, OFS_POWER, 32'h0, '0);
        apb(1'b1, OFS_POWER, 32'h3, '0);
        cpu(4'h0, 22'h30_0200, 1012 + rw, 1035 + rw);
        apb(1'b1, OFS_POWER, 32'h1, '0);
        apb(1'b1, OFS_POWER, 32'h3, '0);
        apb(1'b0, OFS_STATUS, '0, 33'h5);
        repeat (600) @(posedge pclk);
        apb(1'b0, OFS_POWER, '0, 33'h3);
        apb(1'b1, OFS_POWER, 32'h2, '0);
        apb(1'b0, OFS_POWER, '0, 33'h1);
        print_verdict();
    end
endmodule // flash_otp_power_wait_control_tb
